// ===== hw/tcpcmo_params.svh
// Purpose: Offsets, field positions, reset values for the mask and output control bank
// Assumes: Byte-wide register port with 8-bit addresses
// Notes:   Included by the register bank only
`ifndef TCPCMO_PARAMS_SVH
`define TCPCMO_PARAMS_SVH

// ==========================================================
// Offsets
`define TCPCMO_OFS_PWR_MASK    8'h14
`define TCPCMO_OFS_FAULT_MASK  8'h15
`define TCPCMO_OFS_OUT_CFG     8'h18
`define TCPCMO_OFS_PORT_CTRL   8'h19

// ==========================================================
// Reset values
`define TCPCMO_RST_PWR_MASK    8'hFF
`define TCPCMO_RST_FAULT_MASK  8'hB3
`define TCPCMO_RST_OUT_CFG     8'h40
`define TCPCMO_RST_PORT_CTRL   8'h00

// ==========================================================
// Writable bit sets
`define TCPCMO_WMASK_PWR       8'hFF
`define TCPCMO_WMASK_FAULT     8'hB3
`define TCPCMO_WMASK_OUT_CFG   8'hCD
`define TCPCMO_WMASK_PORT_CTRL 8'h33

// ==========================================================
// Field positions
`define TCPCMO_CFG_TRISTATE    7
`define TCPCMO_CFG_DBG         6
`define TCPCMO_CFG_MUX_HI      3
`define TCPCMO_CFG_MUX_LO      2
`define TCPCMO_CFG_FLIP        0
`define TCPCMO_CTL_WDOG        5
`define TCPCMO_CTL_OWNER       4
`define TCPCMO_CTL_SELFTEST    1
`define TCPCMO_CTL_PLUG_FLIP      0

// ==========================================================
// Standard output pin indices
`define TCPCMO_PIN_DBG         0
`define TCPCMO_PIN_MUX_A       1
`define TCPCMO_PIN_MUX_B       2
`define TCPCMO_PIN_FLIP        3
`define TCPCMO_NUM_PINS        4

`endif

// ===== hw/tcpcmo_pkg.sv
// Purpose: Types for the mask and output control bank
// Assumes: Constants live in tcpcmo_params.svh
// Notes:   Pin carrier is one output level plus its enable
`default_nettype none
package tcpcmo_pkg;
   typedef struct packed {
      logic out;
      logic oe;
   } tcpcmo_pin_t;

   typedef logic [7:0] tcpcmo_byte_t;
endpackage : tcpcmo_pkg
`default_nettype wire

// ===== hw/tcpcmo_regs.sv
// Purpose: Interrupt masks, standard output configuration and port control bank
// Assumes: Register port driven by the serial interface engine; one access per cycle
// Notes:   Standard outputs are registered; tri-state drops every enable
`include "tcpcmo_params.svh"
`default_nettype none

module tcpcmo_regs
   import tcpcmo_pkg::*;
(
   input  wire  logic                ref_clk,
   input  wire  logic                sys_rst,
   input  wire  logic                software_reset,
   input  wire  logic                hard_reset_rx,
   input  wire  logic                reg_wr_en,
   input  wire  logic                reg_rd_en,
   input  wire  logic [7:0]          reg_addr,
   input  wire  logic [7:0]          reg_wdata,
   output logic [7:0]                reg_rdata,
   input  wire  logic [7:0]          power_status_reg,
   input  wire  logic [7:0]          fault_status_reg,
   output logic                      port_power_alert,
   output logic                      fault_alert,
   input  wire  logic                int_dbg_indicator_level,
   input  wire  logic [1:0]          int_mux_select_field,
   input  wire  logic                int_plug_flip,
   output tcpcmo_pin_t               dbg_indicator_pin,
   output tcpcmo_pin_t               mux_select_a_pin,
   output tcpcmo_pin_t               mux_select_b_pin,
   output tcpcmo_pin_t               plug_flip_pin,
   output logic                      watchdog_enable,
   output logic                      output_owner_select,
   output logic                      selftest_rx_mode,
   input  wire  logic                goodcrc_sent,
   output logic                      rx_store_enable,
   output logic                      rx_buffer_clear,
   input  wire  logic                conn_power_enable,
   output logic                      conn_power_to_cc1,
   output logic                      conn_power_to_cc2,
   output logic                      bmc_monitor_cc2
);

   // ==========================================================
   // Helpers
   function automatic logic any_masked(input logic [7:0] status, input logic [7:0] mask);
      any_masked = |(status & mask);
   endfunction : any_masked

   function automatic logic wr_hit(input logic en, input logic [7:0] addr, input logic [7:0] ofs);
      wr_hit = en && (addr == ofs);
   endfunction : wr_hit

   // ==========================================================
   // Storage
   tcpcmo_byte_t pwr_mask_reg;
   tcpcmo_byte_t fault_mask_reg;
   tcpcmo_byte_t out_cfg_reg;
   tcpcmo_byte_t port_ctrl_reg;
   tcpcmo_byte_t out_cfg_next;
   tcpcmo_byte_t rdata_next;
   logic         mask_reset;
   logic         ctrl_reset;

   assign mask_reset = software_reset || hard_reset_rx;
   assign ctrl_reset = software_reset;

   // ==========================================================
   // Power status mask
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pwr_mask_reg <= `TCPCMO_RST_PWR_MASK;
      end else if (mask_reset) begin
         pwr_mask_reg <= `TCPCMO_RST_PWR_MASK;
      end else if (wr_hit(reg_wr_en, reg_addr, `TCPCMO_OFS_PWR_MASK)) begin
         pwr_mask_reg <= reg_wdata & `TCPCMO_WMASK_PWR;
      end
   end

   // ==========================================================
   // Fault status mask
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_mask_reg <= `TCPCMO_RST_FAULT_MASK;
      end else if (mask_reset) begin
         fault_mask_reg <= `TCPCMO_RST_FAULT_MASK;
      end else if (wr_hit(reg_wr_en, reg_addr, `TCPCMO_OFS_FAULT_MASK)) begin
         fault_mask_reg <= reg_wdata & `TCPCMO_WMASK_FAULT;
      end
   end

   // ==========================================================
   // Standard output configuration
   always_comb begin
      out_cfg_next = out_cfg_reg;
      if (wr_hit(reg_wr_en, reg_addr, `TCPCMO_OFS_OUT_CFG)) begin
         out_cfg_next = reg_wdata & `TCPCMO_WMASK_OUT_CFG;
         if (!port_ctrl_reg[`TCPCMO_CTL_OWNER]) begin
            out_cfg_next[`TCPCMO_CFG_DBG] = out_cfg_reg[`TCPCMO_CFG_DBG];
         end
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         out_cfg_reg <= `TCPCMO_RST_OUT_CFG;
      end else if (ctrl_reset) begin
         out_cfg_reg <= `TCPCMO_RST_OUT_CFG;
      end else begin
         out_cfg_reg <= out_cfg_next;
      end
   end

   // ==========================================================
   // Port control
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_ctrl_reg <= `TCPCMO_RST_PORT_CTRL;
      end else if (ctrl_reset) begin
         port_ctrl_reg <= `TCPCMO_RST_PORT_CTRL;
      end else if (wr_hit(reg_wr_en, reg_addr, `TCPCMO_OFS_PORT_CTRL)) begin
         port_ctrl_reg <= reg_wdata & `TCPCMO_WMASK_PORT_CTRL;
      end
   end

   // ==========================================================
   // Read port
   always_comb begin
      unique case (reg_addr)
         `TCPCMO_OFS_PWR_MASK:   rdata_next = pwr_mask_reg;
         `TCPCMO_OFS_FAULT_MASK: rdata_next = fault_mask_reg;
         `TCPCMO_OFS_OUT_CFG:    rdata_next = out_cfg_reg;
         `TCPCMO_OFS_PORT_CTRL:  rdata_next = port_ctrl_reg;
         default:                rdata_next = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd_en) begin
         reg_rdata <= rdata_next;
      end
   end

   // ==========================================================
   // Alert flags
   // Levels, not sticky: recomputed from status and mask every cycle
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_power_alert <= 1'b0;
      end else begin
         port_power_alert <= any_masked(power_status_reg, pwr_mask_reg);
      end
   end

   // Reserved fault mask bits stay zero, so their sources never alert
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_alert <= 1'b0;
      end else begin
         fault_alert <= any_masked(fault_status_reg, fault_mask_reg);
      end
   end

   // ==========================================================
   // Standard outputs
   logic [`TCPCMO_NUM_PINS-1:0] pin_level;
   logic [`TCPCMO_NUM_PINS-1:0] pin_out_reg;
   logic [`TCPCMO_NUM_PINS-1:0] pin_oe_reg;
   logic                        host_owns;

   assign host_owns = port_ctrl_reg[`TCPCMO_CTL_OWNER];

   always_comb begin
      if (host_owns) begin
         pin_level[`TCPCMO_PIN_DBG]   = out_cfg_reg[`TCPCMO_CFG_DBG];
         pin_level[`TCPCMO_PIN_MUX_A] = out_cfg_reg[`TCPCMO_CFG_MUX_LO];
         pin_level[`TCPCMO_PIN_MUX_B] = out_cfg_reg[`TCPCMO_CFG_MUX_HI];
         pin_level[`TCPCMO_PIN_FLIP]  = out_cfg_reg[`TCPCMO_CFG_FLIP];
      end else begin
         pin_level[`TCPCMO_PIN_DBG]   = int_dbg_indicator_level;
         pin_level[`TCPCMO_PIN_MUX_A] = int_mux_select_field[0];
         pin_level[`TCPCMO_PIN_MUX_B] = int_mux_select_field[1];
         pin_level[`TCPCMO_PIN_FLIP]  = int_plug_flip;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `TCPCMO_NUM_PINS; gi++) begin : g_pin
         always_ff @(posedge ref_clk or posedge sys_rst) begin
            if (sys_rst) begin
               pin_out_reg[gi] <= 1'b0;
               pin_oe_reg[gi]  <= 1'b0;
            end else begin
               pin_out_reg[gi] <= pin_level[gi];
               pin_oe_reg[gi]  <= ~out_cfg_reg[`TCPCMO_CFG_TRISTATE];
            end
         end
      end
   endgenerate

   assign dbg_indicator_pin = '{out: pin_out_reg[`TCPCMO_PIN_DBG],   oe: pin_oe_reg[`TCPCMO_PIN_DBG]};
   assign mux_select_a_pin  = '{out: pin_out_reg[`TCPCMO_PIN_MUX_A], oe: pin_oe_reg[`TCPCMO_PIN_MUX_A]};
   assign mux_select_b_pin  = '{out: pin_out_reg[`TCPCMO_PIN_MUX_B], oe: pin_oe_reg[`TCPCMO_PIN_MUX_B]};
   assign plug_flip_pin     = '{out: pin_out_reg[`TCPCMO_PIN_FLIP],  oe: pin_oe_reg[`TCPCMO_PIN_FLIP]};

   // ==========================================================
   // Port control outputs
   assign watchdog_enable     = port_ctrl_reg[`TCPCMO_CTL_WDOG];
   assign output_owner_select = host_owns;
   assign selftest_rx_mode    = port_ctrl_reg[`TCPCMO_CTL_SELFTEST];
   assign rx_store_enable     = ~port_ctrl_reg[`TCPCMO_CTL_SELFTEST];

   // In self-test receive mode, buffer clear fires the cycle after the acknowledge goes out
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         rx_buffer_clear <= 1'b0;
      end else begin
         rx_buffer_clear <= goodcrc_sent && port_ctrl_reg[`TCPCMO_CTL_SELFTEST];
      end
   end

   // ==========================================================
   // Plug orientation
   // Power is routed only while the source is enabled, so both legs stay off otherwise
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         conn_power_to_cc1 <= 1'b0;
      end else begin
         conn_power_to_cc1 <= conn_power_enable && port_ctrl_reg[`TCPCMO_CTL_PLUG_FLIP];
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         conn_power_to_cc2 <= 1'b0;
      end else begin
         conn_power_to_cc2 <= conn_power_enable && !port_ctrl_reg[`TCPCMO_CTL_PLUG_FLIP];
      end
   end

   // Monitor side follows the orientation bit alone
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bmc_monitor_cc2 <= 1'b0;
      end else begin
         bmc_monitor_cc2 <= port_ctrl_reg[`TCPCMO_CTL_PLUG_FLIP];
      end
   end

endmodule : tcpcmo_regs
`default_nettype wire

// ===== test/tcpcmo_props.sv
// Purpose: Port checks for the mask and output control bank
// Assumes: One clock domain, asynchronous active-high reset
// Notes:   Bound to every instance of the register bank
`default_nettype none
module tcpcmo_props
   import tcpcmo_pkg::*;
(
   input wire logic        ref_clk,
   input wire logic        sys_rst,
   input wire logic        software_reset,
   input wire logic        reg_wr_en,
   input wire logic        reg_rd_en,
   input wire logic [7:0]  reg_addr,
   input wire logic [7:0]  reg_rdata,
   input wire logic [7:0]  power_status_reg,
   input wire logic [7:0]  fault_status_reg,
   input wire logic        port_power_alert,
   input wire logic        fault_alert,
   input wire logic        int_dbg_indicator_level,
   input wire logic [1:0]  int_mux_select_field,
   input wire tcpcmo_pin_t dbg_indicator_pin,
   input wire tcpcmo_pin_t mux_select_a_pin,
   input wire tcpcmo_pin_t mux_select_b_pin,
   input wire tcpcmo_pin_t plug_flip_pin,
   input wire logic        output_owner_select,
   input wire logic        selftest_rx_mode,
   input wire logic        goodcrc_sent,
   input wire logic        rx_store_enable,
   input wire logic        rx_buffer_clear,
   input wire logic        conn_power_enable,
   input wire logic        conn_power_to_cc1,
   input wire logic        conn_power_to_cc2,
   input wire logic        bmc_monitor_cc2
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Properties
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   sequence s_rd(logic [7:0] ad);
      reg_rd_en && reg_addr == ad;
   endsequence
   sequence s_sw;
      software_reset ##1 !reg_wr_en;
   endsequence
   a_unmapped_rd: assert property (reg_rd_en && !(reg_addr inside {8'h14, 8'h15, 8'h18, 8'h19})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_fault_rsvd: assert property (s_rd(8'h15) |=> (reg_rdata & 8'h4C) == 8'h00)
      else $error("fault mask reserved bit set");
   a_cfg_rsvd: assert property (s_rd(8'h18) |=> (reg_rdata & 8'h32) == 8'h00)
      else $error("output config reserved bit set");
   a_ctrl_fixed: assert property (s_rd(8'h19) |=> (reg_rdata & 8'hCC) == 8'h00)
      else $error("port control fixed bits set");
   a_swrst_defaults: assert property (s_sw |-> (!output_owner_select && !selftest_rx_mode) ##1 plug_flip_pin.oe)
      else $error("software reset left controls set");
   a_owner_internal: assert property (!output_owner_select |=> !dbg_indicator_pin.oe
      || (dbg_indicator_pin.out == $past(int_dbg_indicator_level)
      && {mux_select_b_pin.out, mux_select_a_pin.out} == $past(int_mux_select_field)))
      else $error("pins ignore internal drivers");
   a_oe_uniform: assert property (dbg_indicator_pin.oe == plug_flip_pin.oe
      && mux_select_a_pin.oe == mux_select_b_pin.oe && dbg_indicator_pin.oe == mux_select_a_pin.oe)
      else $error("output enables differ");
   a_selftest_clear: assert property (1'b1 |=> rx_buffer_clear == ($past(goodcrc_sent) && $past(selftest_rx_mode)))
      else $error("receive clear wrong");
   a_store_mode: assert property (rx_store_enable != selftest_rx_mode)
      else $error("store enable wrong");
   a_plug_flip_route: assert property (1'b1 |=> (conn_power_to_cc1 == ($past(conn_power_enable) && bmc_monitor_cc2))
      && (conn_power_to_cc2 == ($past(conn_power_enable) && !bmc_monitor_cc2))) else $error("orientation wrong");
   a_pwr_alert: assert property (power_status_reg == 8'h00 |=> !port_power_alert)
      else $error("power alert without status");
   a_fault_alert: assert property ((fault_status_reg & 8'hB3) == 8'h00 |=> !fault_alert)
      else $error("fault alert without status");
endmodule : tcpcmo_props
bind tcpcmo_regs tcpcmo_props chk_u (.*);
`default_nettype wire

// ===== test/tcpcmo_host.sv
// Purpose: Port manager model issuing register accesses
// Assumes: Accesses start and end on falling edges
// Notes:   Idle address and data show the inverse of the last value
`default_nettype none
module tcpcmo_host (
   input  wire logic       ref_clk,
   output logic            reg_wr_en,
   output logic            reg_rd_en,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================================
   // Access
   initial begin
      {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = '0;
   end
   task acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
      @(negedge ref_clk);
      {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {w, !w, a, d};
      @(negedge ref_clk);
      {reg_wr_en, reg_rd_en, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
      q = reg_rdata;
   endtask : acc
endmodule : tcpcmo_host
`default_nettype wire

// ===== test/tb_tcpc_mask_and_output_control.sv
// Purpose: Self-checking bench for the mask and output control bank
// Assumes: Inputs change on falling edges
// Notes:   A shadow copy of the registers predicts every read
`default_nettype none
module tb_tcpc_mask_and_output_control
   import tcpcmo_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, sys_rst, software_reset, hard_reset_rx, reg_wr_en, reg_rd_en, port_power_alert, fault_alert;
   logic int_dbg_indicator_level, int_plug_flip, watchdog_enable, output_owner_select, selftest_rx_mode;
   logic goodcrc_sent, rx_store_enable, rx_buffer_clear, conn_power_enable, conn_power_to_cc1, conn_power_to_cc2;
   logic bmc_monitor_cc2;
   logic [1:0] int_mux_select_field;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, power_status_reg, fault_status_reg;
   tcpcmo_pin_t dbg_indicator_pin, mux_select_a_pin, mux_select_b_pin, plug_flip_pin;
   logic [7:0] sh [0:255] = '{default: 8'h00};
   logic [7:0] ofs [5] = '{8'h14, 8'h15, 8'h18, 8'h19, 8'h16};
   logic [31:0] x = 32'hC5B5;
   int miscompares = 0;
   int n_checks = 0;
   tcpcmo_regs dut_u (.*);
   tcpcmo_host host_u (.*);
   // ==========================================================
   // Helpers
   function logic [31:0] rnd();
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : rnd
   function logic [7:0] nxt(input logic [7:0] a, input logic [7:0] d);
      case (a)
         8'h14: return d;
         8'h15: return d & 8'hB3;
         8'h18: return (d & 8'h8D) | ((sh[8'h19][4] ? d : sh[8'h18]) & 8'h40);
         8'h19: return d & 8'h33;
         default: return 8'h00;
      endcase
   endfunction : nxt
   task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      host_u.acc(1'b1, a, d, q);
      sh[a] = nxt(a, d);
   endtask : wr
   task rd(input logic [7:0] a);
      logic [7:0] q;
      host_u.acc(1'b0, a, 8'h00, q);
      chk("rdata", q, sh[a]);
   endtask : rd
   task defaults(input logic hard);
      sh[8'h14] = 8'hFF;
      sh[8'h15] = 8'hB3;
      if (!hard) begin
         sh[8'h18] = 8'h40;
         sh[8'h19] = 8'h00;
      end
      foreach (ofs[i]) rd(ofs[i]);
   endtask : defaults
   task pulse(input logic hard);
      @(negedge ref_clk);
      {hard_reset_rx, software_reset} = {hard, !hard};
      @(negedge ref_clk);
      {hard_reset_rx, software_reset} = 2'b00;
      defaults(hard);
   endtask : pulse
   task pins(input logic [3:0] e, input logic oe);
      logic [3:0] o;
      logic [3:0] v;
      o = {plug_flip_pin.out, mux_select_b_pin.out, mux_select_a_pin.out, dbg_indicator_pin.out};
      v = {plug_flip_pin.oe, mux_select_b_pin.oe, mux_select_a_pin.oe, dbg_indicator_pin.oe};
      chk("pins", {oe ? o : 4'h0, v}, {e, {4{oe}}});
   endtask : pins
   function logic [7:0] ctl_seen();
      return {output_owner_select, watchdog_enable, selftest_rx_mode, rx_store_enable, rx_buffer_clear,
         conn_power_to_cc1, conn_power_to_cc2, bmc_monitor_cc2};
   endfunction : ctl_seen
   task conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : conclude
   // ==========================================================
   // Sequence
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   initial begin
      #200us;
      miscompares++;
      conclude();
   end
   initial begin
      {sys_rst, software_reset, hard_reset_rx, goodcrc_sent, conn_power_enable} = 5'b10000;
      {int_dbg_indicator_level, int_plug_flip, int_mux_select_field} = 4'h0;
      {power_status_reg, fault_status_reg} = 16'h0000;
      repeat (20) @(negedge ref_clk);
      sys_rst = 1'b0;
      defaults(1'b0);
      repeat (60) begin
         {power_status_reg, fault_status_reg} = 16'(rnd());
         {int_dbg_indicator_level, int_plug_flip, int_mux_select_field, conn_power_enable} = 5'(rnd());
         wr(ofs[rnd() % 5], 8'(rnd()));
         rd(ofs[rnd() % 5]);
         chk("palert", 8'(port_power_alert), 8'(|(power_status_reg & sh[8'h14])));
         chk("falert", 8'(fault_alert), 8'(|(fault_status_reg & sh[8'h15])));
      end
      {power_status_reg, fault_status_reg} = 16'h0000;
      wr(8'h19, 8'h00);
      wr(8'h18, 8'h00);
      @(negedge ref_clk);
      pins({int_plug_flip, int_mux_select_field, int_dbg_indicator_level}, 1'b1);
      wr(8'h19, 8'h10);
      for (logic [2:0] m = 0; m < 4; m++) begin
         wr(8'h18, {1'b0, m[0], 2'b00, m[1:0], 1'b0, m[1]});
         @(negedge ref_clk);
         pins({m[1], m[1], m[0], m[0]}, 1'b1);
      end
      wr(8'h18, 8'h80);
      @(negedge ref_clk);
      pins(4'h0, 1'b0);
      wr(8'h19, 8'h23);
      conn_power_enable = 1'b1;
      goodcrc_sent = 1'b1;
      @(negedge ref_clk);
      goodcrc_sent = 1'b0;
      chk("ctrl", ctl_seen(), 8'h6D);
      wr(8'h19, 8'h00);
      @(negedge ref_clk);
      chk("ctrl", ctl_seen(), 8'h12);
      wr(8'h19, 8'h31);
      wr(8'h14, 8'h5A);
      wr(8'h15, 8'h00);
      chk("ctrl", ctl_seen(), 8'hD5);
      pulse(1'b1);
      pulse(1'b0);
      conclude();
   end
endmodule : tb_tcpc_mask_and_output_control
`default_nettype wire
